/* File: hw/ais_cfg.svh */
// constants for the alu instruction subset block: offsets, bit positions, reset values
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH

// register map on the plain software port (byte offsets)
`define AIS_ADDR_ACC      8'h00
`define AIS_ADDR_STATUS   8'h04

// status register bit positions
`define AIS_ST_CARRY      0
`define AIS_ST_NIBBLE     1
`define AIS_ST_ZERO       2
`define AIS_ST_PWRDN_N    3
`define AIS_ST_TMOUT_N    4
`define AIS_ST_SLEEP      5
`define AIS_ST_RSVD_HI    7

// reset values
`define AIS_ACC_RST       8'h00
`define AIS_FLAG_RST      1'b0
`define AIS_FLAG_N_RST    1'b1
`define AIS_RDATA_RST     8'h00

// value the watchdog counter takes on power-down
`define AIS_WDOG_CLEAR_VAL 8'h00

// data path widths and nibble split
`define AIS_NIB_LO        3
`define AIS_NIB_HI        4
`define AIS_MSB           7
`define AIS_ADDR_W        7

`endif

/* File: hw/ais_pkg.sv */
// types shared by the alu instruction subset block
package ais_pkg;

  typedef enum logic [2:0] {
    powerdown_op            = 3'h0,
    rotate_right_carry_op   = 3'h1,
    literal_minus_acc_op    = 3'h2,
    reg_minus_acc_op        = 3'h3,
    exclusive_or_reg_op     = 3'h4,
    nibble_exchange_op      = 3'h5,
    exclusive_or_literal_op = 3'h6,
    no_op                   = 3'h7
  } ais_op_e;

  // run -> sleep -> run, one bit changes per step
  typedef enum logic [1:0] {
    ais_run   = 2'h0,
    ais_sleep = 2'h1
  } ais_state_e;

  typedef struct packed {
    ais_op_e    op;
    logic       dest;
    logic [6:0] addr;
    logic [7:0] lit;
  } ais_insn_s;

  typedef struct packed {
    logic carry;
    logic nibble;
    logic zero;
  } ais_flags_s;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } ais_fwr_s;

endpackage : ais_pkg

/* File: hw/ais_sync2.sv */
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module ais_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : ais_sync2

/* File: hw/ais_alu.sv */
// combinational result and flag logic for the instruction subset
`timescale 1ns/1ps
`include "ais_cfg.svh"
module ais_alu
  import ais_pkg::*;
(
  input  ais_op_e          op,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  freg,
  input  wire logic [7:0]  lit,
  input  wire logic        carry_in,
  output logic      [7:0]  result,
  output ais_flags_s       flags,
  output ais_flags_s       upd
);
  logic [7:0] minuend;

  always_comb begin
    minuend = (op == literal_minus_acc_op) ? lit : freg; // RQ6
    result  = 8'h00;
    flags   = '0;
    upd     = '0;
    case (op)
      rotate_right_carry_op: begin
        result       = {carry_in, freg[`AIS_MSB:1]}; // RQ4
        flags.carry  = freg[0]; // RQ4
        upd.carry    = 1'b1;
      end
      literal_minus_acc_op, reg_minus_acc_op: begin
        result       = minuend - acc; // RQ7 RQ9
        flags.carry  = (acc <= minuend); // RQ8 RQ10
        flags.nibble = (acc[`AIS_NIB_LO:0] <= minuend[`AIS_NIB_LO:0]); // RQ8 RQ10
        upd          = '1;
      end
      exclusive_or_reg_op: begin
        result       = acc ^ freg; // RQ11
        upd.zero     = 1'b1;
      end
      exclusive_or_literal_op: begin
        result       = acc ^ lit; // RQ13
        upd.zero     = 1'b1;
      end
      nibble_exchange_op: begin
        result = {freg[`AIS_NIB_LO:0], freg[`AIS_MSB:`AIS_NIB_HI]}; // RQ12
      end
      default: begin
        result = 8'h00;
      end
    endcase
    flags.zero = (result == 8'h00); // RQ14
  end
endmodule : ais_alu

/* File: hw/ais_core.sv */
// What this block does
// RQ1: power-down clears watchdog counter and prescaler
// RQ2: power-down clears powerdown flag, sets timeout flag
// RQ3: power-down halts core, stops oscillator
// RQ4: rotate right through carry, carry only
// RQ5: dest zero to accumulator, one to register
// RQ6: literal forms use 8-bit instruction literal
// RQ7: literal minus accumulator into accumulator
// RQ8: carry and nibble carry mean acc not greater
// RQ9: register minus accumulator to chosen destination
// RQ10: same carry and nibble rules versus register
// RQ11: xor with register, zero flag only
// RQ12: swap nibbles, no flags touched
// RQ13: xor with literal into accumulator, zero only
// RQ14: zero flag set when result is zero
// RQ15: one cycle each, 128 register addresses
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ais_cfg.svh"
module ais_core
  import ais_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        exec_valid,
  output logic             exec_ready,
  input  ais_insn_s        insn,
  input  wire logic [7:0]  file_rdata,
  output ais_fwr_s         file_wr,
  output logic      [7:0]  acc_out,
  output logic             carry_flag,
  output logic             nibble_carry_flag,
  output logic             zero_flag,
  output logic             timeout_flag_n,
  output logic             powerdown_flag_n,
  output logic             watchdog_counter_clr,
  output logic             watchdog_prescaler_clr,
  output logic      [7:0]  watchdog_counter_load,
  output logic             sleep_state,
  output logic             osc_stop,
  input  wire logic        wake_in,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata
);

  ais_state_e  state_ff;
  ais_state_e  nxt_state;
  logic [7:0]  acc_ff;
  ais_flags_s  flags_ff;
  logic        tmout_n_ff;
  logic        pwrdn_n_ff;
  ais_fwr_s    fwr_ff;
  logic        wdog_clr_ff;
  logic        pre_clr_ff;
  logic [7:0]  wdog_load_ff;
  logic [7:0]  rdata_ff;
  logic        wake_sync;
  logic        take;
  logic [7:0]  alu_res;
  ais_flags_s  alu_flags;
  ais_flags_s  alu_upd;
  logic        to_acc;
  logic        to_reg;
  logic        wr_acc;
  logic        wr_stat;
  logic [7:0]  status_word;

  ais_sync2 #(
    .W        (1)
  ) u_wake_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (wake_in),
    .sync_out (wake_sync)
  );

  ais_alu u_alu (
    .op       (insn.op),
    .acc      (acc_ff),
    .freg     (file_rdata),
    .lit      (insn.lit),
    .carry_in (flags_ff.carry),
    .result   (alu_res),
    .flags    (alu_flags),
    .upd      (alu_upd)
  );

  // halted core takes no instruction until wake
  assign exec_ready = (state_ff == ais_run); // RQ3
  assign take       = exec_valid && exec_ready; // RQ15

  // literal forms and sleep always land in the accumulator or nowhere
  always_comb begin
    to_acc = 1'b0;
    to_reg = 1'b0;
    case (insn.op)
      literal_minus_acc_op, exclusive_or_literal_op: begin
        to_acc = 1'b1;
      end
      rotate_right_carry_op, reg_minus_acc_op, exclusive_or_reg_op,
      nibble_exchange_op: begin
        to_acc = !insn.dest; // RQ5
        to_reg = insn.dest; // RQ5
      end
      default: begin
        to_acc = 1'b0;
      end
    endcase
  end

  assign wr_acc  = bus_wr && (bus_addr == `AIS_ADDR_ACC);
  assign wr_stat = bus_wr && (bus_addr == `AIS_ADDR_STATUS);

  // state machine: sleep entry wins over a wake seen the same cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ais_run: begin
        if (take && insn.op == powerdown_op) begin
          nxt_state = ais_sleep; // RQ3
        end
      end
      ais_sleep: begin
        if (wake_sync) begin
          nxt_state = ais_run;
        end
      end
      default: begin
        nxt_state = ais_run;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ais_run;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // accumulator: an executing instruction wins over a software write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= `AIS_ACC_RST;
    end else if (take && to_acc) begin
      acc_ff <= alu_res; // RQ5 RQ7 RQ13
    end else if (wr_acc) begin
      acc_ff <= bus_wdata;
    end
  end

  // arithmetic flags: per-flag, hardware update wins over software write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= '0;
    end else begin
      if (take && alu_upd.carry) begin
        flags_ff.carry <= alu_flags.carry; // RQ4 RQ8 RQ10
      end else if (wr_stat) begin
        flags_ff.carry <= bus_wdata[`AIS_ST_CARRY];
      end
      if (take && alu_upd.nibble) begin
        flags_ff.nibble <= alu_flags.nibble; // RQ8 RQ10
      end else if (wr_stat) begin
        flags_ff.nibble <= bus_wdata[`AIS_ST_NIBBLE];
      end
      if (take && alu_upd.zero) begin
        flags_ff.zero <= alu_flags.zero; // RQ14
      end else if (wr_stat) begin
        flags_ff.zero <= bus_wdata[`AIS_ST_ZERO];
      end
    end
  end

  // time-out and power-down flags are hardware-only; software cannot write them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tmout_n_ff <= `AIS_FLAG_N_RST;
      pwrdn_n_ff <= `AIS_FLAG_N_RST;
    end else if (take && insn.op == powerdown_op) begin
      tmout_n_ff <= 1'b1; // RQ2
      pwrdn_n_ff <= 1'b0; // RQ2
    end
  end

  // watchdog clears as one-cycle pulses; the counter load value is held at the clear value
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdog_clr_ff  <= `AIS_FLAG_RST;
      pre_clr_ff   <= `AIS_FLAG_RST;
      wdog_load_ff <= `AIS_WDOG_CLEAR_VAL;
    end else begin
      wdog_clr_ff  <= take && (insn.op == powerdown_op); // RQ1
      pre_clr_ff   <= take && (insn.op == powerdown_op); // RQ1
      wdog_load_ff <= `AIS_WDOG_CLEAR_VAL; // RQ1
    end
  end

  // write-back port toward the file register memory
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fwr_ff <= '0;
    end else begin
      fwr_ff.en <= take && to_reg; // RQ5 RQ9 RQ11 RQ12
      if (take && to_reg) begin
        fwr_ff.addr <= insn.addr; // RQ15
        fwr_ff.data <= alu_res;
      end
    end
  end

  always_comb begin
    status_word                      = 8'h00;
    status_word[`AIS_ST_CARRY]       = flags_ff.carry;
    status_word[`AIS_ST_NIBBLE]      = flags_ff.nibble;
    status_word[`AIS_ST_ZERO]        = flags_ff.zero;
    status_word[`AIS_ST_PWRDN_N]     = pwrdn_n_ff;
    status_word[`AIS_ST_TMOUT_N]     = tmout_n_ff;
    status_word[`AIS_ST_SLEEP]       = (state_ff == ais_sleep);
  end

  // read data stands one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= `AIS_RDATA_RST;
    end else if (bus_rd) begin
      case (bus_addr)
        `AIS_ADDR_ACC:    rdata_ff <= acc_ff;
        `AIS_ADDR_STATUS: rdata_ff <= status_word;
        default:          rdata_ff <= `AIS_RDATA_RST;
      endcase
    end else begin
      rdata_ff <= `AIS_RDATA_RST;
    end
  end

  assign file_wr                = fwr_ff;
  assign acc_out                = acc_ff;
  assign carry_flag             = flags_ff.carry;
  assign nibble_carry_flag      = flags_ff.nibble;
  assign zero_flag              = flags_ff.zero;
  assign timeout_flag_n         = tmout_n_ff;
  assign powerdown_flag_n       = pwrdn_n_ff;
  assign watchdog_counter_clr   = wdog_clr_ff;
  assign watchdog_prescaler_clr = pre_clr_ff;
  assign watchdog_counter_load  = wdog_load_ff;
  assign sleep_state            = (state_ff == ais_sleep);
  assign osc_stop               = (state_ff == ais_sleep); // RQ3
  assign bus_rdata              = rdata_ff;

  // checks on the data path and the power-down sequence
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_sleep_taken;
    take && insn.op == powerdown_op;
  endsequence

  sequence s_sleep_effects;
    !pwrdn_n_ff && tmout_n_ff && wdog_clr_ff && pre_clr_ff && sleep_state && osc_stop;
  endsequence

  sequence s_halted;
    !exec_ready && !fwr_ff.en;
  endsequence

  wdog_clear_a: assert property ( // RQ1
      s_sleep_taken |=> wdog_clr_ff && pre_clr_ff && wdog_load_ff == `AIS_WDOG_CLEAR_VAL
      ##1 !wdog_clr_ff && !pre_clr_ff)
    else $error("watchdog not cleared once on power-down");

  sleep_flags_a: assert property (s_sleep_taken |=> s_sleep_effects) // RQ2
    else $error("power-down flag effects wrong");

  sleep_keeps_a: assert property ( // RQ2
      s_sleep_taken |=> $stable(flags_ff) && $stable(acc_ff))
    else $error("power-down touched other state");

  sleep_halt_a: assert property (s_sleep_taken ##1 !wake_sync |=> s_halted) // RQ3
    else $error("core not halted after power-down");

  // software may still load the accumulator while asleep, so that cycle is left out
  sleep_refuse_a: assert property ( // RQ3
      sleep_state && !wr_acc |=> $stable(acc_ff) && !fwr_ff.en)
    else $error("sleeping core changed the accumulator or wrote back");

  rotate_res_a: assert property ( // RQ4
      take && insn.op == rotate_right_carry_op && insn.dest
      |=> fwr_ff.en && fwr_ff.data == {$past(flags_ff.carry), $past(file_rdata[7:1])}
      && flags_ff.carry == $past(file_rdata[0]) && $stable(flags_ff.zero))
    else $error("rotate right result or carry wrong");

  dest_acc_a: assert property ( // RQ5
      take && insn.dest == 1'b0 && insn.op != powerdown_op && insn.op != no_op
      |=> !fwr_ff.en && acc_ff == $past(alu_res))
    else $error("dest zero did not land in accumulator");

  sub_lit_a: assert property ( // RQ7 RQ8
      take && insn.op == literal_minus_acc_op
      |=> acc_ff == 8'($past(insn.lit) - $past(acc_ff))
      && flags_ff.carry == ($past(acc_ff) <= $past(insn.lit)))
    else $error("literal subtract wrong");

  // zero is checked from the operands, not from the alu's own result
  lit_nibble_a: assert property ( // RQ8
      take && insn.op == literal_minus_acc_op
      |=> flags_ff.nibble == ($past(acc_ff[3:0]) <= $past(insn.lit[3:0]))
      && flags_ff.zero == ($past(acc_ff) == $past(insn.lit)))
    else $error("literal subtract nibble carry or zero wrong");

  sub_reg_a: assert property ( // RQ9 RQ10
      take && insn.op == reg_minus_acc_op && insn.dest
      |=> fwr_ff.data == 8'($past(file_rdata) - $past(acc_ff))
      && flags_ff.nibble == ($past(acc_ff[3:0]) <= $past(file_rdata[3:0])))
    else $error("register subtract wrong");

  reg_carry_a: assert property ( // RQ10
      take && insn.op == reg_minus_acc_op
      |=> flags_ff.carry == ($past(acc_ff) <= $past(file_rdata)))
    else $error("register subtract carry wrong");

  xor_reg_a: assert property ( // RQ11
      take && insn.op == exclusive_or_reg_op && !insn.dest
      |=> acc_ff == ($past(acc_ff) ^ $past(file_rdata))
      && flags_ff.carry == $past(flags_ff.carry))
    else $error("xor with register wrong");

  xor_wb_a: assert property ( // RQ11
      take && insn.op == exclusive_or_reg_op && insn.dest
      |=> fwr_ff.en && fwr_ff.data == ($past(acc_ff) ^ $past(file_rdata))
      && $stable(acc_ff) && flags_ff.nibble == $past(flags_ff.nibble))
    else $error("xor with register write-back wrong");

  swap_nib_a: assert property ( // RQ12
      take && insn.op == nibble_exchange_op && insn.dest
      |=> fwr_ff.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
      && $stable(flags_ff))
    else $error("nibble swap wrong");

  xor_lit_a: assert property ( // RQ13 RQ6
      take && insn.op == exclusive_or_literal_op
      |=> acc_ff == ($past(acc_ff) ^ $past(insn.lit))
      && flags_ff.zero == ($past(acc_ff) == $past(insn.lit)))
    else $error("xor with literal wrong");

  zero_flag_a: assert property ( // RQ14
      take && alu_upd.zero
      |=> flags_ff.zero == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");

  // the enable must drop unless a new register-bound instruction was taken
  one_cycle_a: assert property ( // RQ15
      take && to_reg |=> fwr_ff.en && fwr_ff.addr == $past(insn.addr)
      ##1 (fwr_ff.en == ($past(take) && $past(to_reg))))
    else $error("write-back not a one-cycle pulse after take");

endmodule : ais_core

/* File: bench/ais_file_model.sv */
// file register memory that feeds operands to the core and takes its write-backs
`timescale 1ns/1ps
module ais_file_model
  import ais_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       exec_valid,
  input  ais_insn_s       insn,
  input  ais_fwr_s        file_wr,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [128];

  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 29 + 7);
    end
  end

  // outside a request the operand bus shows the inverse, so a stale read cannot pass
  assign file_rdata = exec_valid ? mem[insn.addr] : ~mem[insn.addr];

  always @(posedge ref_clk) begin
    if (file_wr.en) begin
      mem[file_wr.addr] <= file_wr.data;
    end
  end
endmodule : ais_file_model

/* File: bench/tb.sv */
// self-checking bench for the alu instruction subset core
`timescale 1ns/1ps
`include "ais_cfg.svh"
module tb;
  import ais_pkg::*;
  logic       ref_clk, nrst, exec_valid, exec_ready, wake_in, bus_wr, bus_rd;
  logic       carry_flag, nibble_carry_flag, zero_flag, timeout_flag_n, powerdown_flag_n;
  logic       watchdog_counter_clr, watchdog_prescaler_clr, sleep_state, osc_stop;
  logic [7:0] file_rdata, acc_out, watchdog_counter_load, bus_addr, bus_wdata, bus_rdata;
  ais_insn_s  insn;
  ais_fwr_s   file_wr;
  int         n_errors, n_compared;
  logic [7:0] e_acc;
  logic       e_c, e_nc, e_z, e_tm, e_pw, e_sleep;

  ais_core u_ais_core (.ref_clk, .nrst, .exec_valid, .exec_ready, .insn, .file_rdata,
    .file_wr, .acc_out, .carry_flag, .nibble_carry_flag, .zero_flag, .timeout_flag_n,
    .powerdown_flag_n, .watchdog_counter_clr, .watchdog_prescaler_clr,
    .watchdog_counter_load, .sleep_state, .osc_stop, .wake_in, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata);
  ais_file_model u_ais_file_model (.ref_clk, .exec_valid, .insn, .file_wr, .file_rdata);

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  function automatic logic [7:0] stat();
    return {2'b00, e_sleep, e_tm, e_pw, e_z, e_nc, e_c};
  endfunction : stat

  task automatic chk_state();
    chk8(acc_out, e_acc, "acc");
    chk1(carry_flag, e_c, "carry");
    chk1(nibble_carry_flag, e_nc, "nibble");
    chk1(zero_flag, e_z, "zero");
    chk1(timeout_flag_n, e_tm, "tm_n");
    chk1(powerdown_flag_n, e_pw, "pw_n");
  endtask : chk_state

  task automatic run_op(input ais_op_e op, input logic d, input logic [6:0] a,
                        input logic [7:0] k);
    logic [7:0] f, r;
    logic       wr, pw;
    @(posedge ref_clk);
    exec_valid <= 1'b1;
    insn <= '{op: op, dest: d, addr: a, lit: k};
    @(posedge ref_clk);
    exec_valid <= 1'b0;
    f = u_ais_file_model.mem[a];
    pw = (op == powerdown_op) && !e_sleep;
    wr = 1'b0;
    r = e_acc;
    // literal forms always land in the accumulator
    if (op == literal_minus_acc_op || op == exclusive_or_literal_op) begin
      f = k;
      d = 1'b0;
    end
    if (!e_sleep) begin
      case (op)
        powerdown_op: begin
          e_pw = 1'b0;
          e_tm = 1'b1;
        end
        rotate_right_carry_op: begin
          r = {e_c, f[7:1]};
          e_c = f[0];
        end
        literal_minus_acc_op, reg_minus_acc_op: begin
          r = f - e_acc;
          e_c = e_acc <= f;
          e_nc = e_acc[3:0] <= f[3:0];
          e_z = r == 8'h00;
        end
        exclusive_or_reg_op, exclusive_or_literal_op: begin
          r = e_acc ^ f;
          e_z = r == 8'h00;
        end
        nibble_exchange_op: r = {f[3:0], f[7:4]};
        default: ;
      endcase
      if (op != powerdown_op && op != no_op) begin
        wr = d;
        if (!d) e_acc = r;
      end
    end
    e_sleep = e_sleep | pw;
    @(negedge ref_clk);
    chk_state();
    chk1(file_wr.en, wr, "wr_en");
    if (wr) begin
      chk8(file_wr.data, r, "wr_data");
      chk8({1'b0, file_wr.addr}, {1'b0, a}, "wr_addr");
    end
    chk1(watchdog_counter_clr, pw, "wd_clr");
    chk1(watchdog_prescaler_clr, pw, "pre_clr");
    chk8(watchdog_counter_load, `AIS_WDOG_CLEAR_VAL, "wd_load");
    chk1(sleep_state, e_sleep, "sleep");
    chk1(osc_stop, e_sleep, "osc");
    chk1(exec_ready, !e_sleep, "ready");
  endtask : run_op

  task automatic bus_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    if (a == `AIS_ADDR_ACC) e_acc = d;
    if (a == `AIS_ADDR_STATUS) {e_z, e_nc, e_c} = d[2:0];
    @(negedge ref_clk);
  endtask : bus_w

  task automatic bus_r(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    chk8(bus_rdata, exp, "rdata");
  endtask : bus_r

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {nrst, exec_valid, wake_in, bus_wr, bus_rd} = '0;
    {insn, bus_addr, bus_wdata} = '0;
    {e_acc, e_c, e_nc, e_z, e_sleep} = '0;
    {e_tm, e_pw} = 2'b11;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(32'hb2da));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk_state();
    bus_r(`AIS_ADDR_STATUS, stat());
    $display("test reset done");
    bus_w(`AIS_ADDR_ACC, 8'h5a);
    run_op(literal_minus_acc_op, 1'b1, 7'h00, 8'h5a);
    bus_w(`AIS_ADDR_ACC, 8'h10);
    run_op(literal_minus_acc_op, 1'b0, 7'h00, 8'h0f);
    bus_w(`AIS_ADDR_ACC, 8'h01);
    run_op(literal_minus_acc_op, 1'b0, 7'h00, 8'h10);
    run_op(reg_minus_acc_op, 1'b1, 7'h7f, 8'h00);
    run_op(reg_minus_acc_op, 1'b0, 7'h7f, 8'h00);
    run_op(exclusive_or_literal_op, 1'b1, 7'h00, e_acc);
    run_op(exclusive_or_reg_op, 1'b1, 7'h05, 8'h00);
    run_op(rotate_right_carry_op, 1'b1, 7'h03, 8'h00);
    run_op(rotate_right_carry_op, 1'b0, 7'h03, 8'h00);
    run_op(nibble_exchange_op, 1'b0, 7'h00, 8'h00);
    run_op(no_op, 1'b0, 7'h00, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 80; i++) begin
      if ($urandom_range(0, 7) == 0) bus_w(`AIS_ADDR_STATUS, 8'($urandom));
      run_op(ais_op_e'($urandom_range(1, 6)), 1'($urandom), 7'($urandom),
             8'($urandom));
    end
    $display("test random done");
    bus_w(`AIS_ADDR_STATUS, 8'hff);
    bus_r(`AIS_ADDR_STATUS, stat());
    bus_w(8'h08, 8'hff);
    bus_r(8'h08, 8'h00);
    bus_r(`AIS_ADDR_ACC, e_acc);
    $display("test registers done");
    run_op(powerdown_op, 1'b0, 7'h00, 8'h00);
    run_op(exclusive_or_literal_op, 1'b0, 7'h00, 8'ha5);
    bus_r(`AIS_ADDR_STATUS, stat());
    @(posedge ref_clk);
    wake_in <= 1'b1;
    for (int i = 0; i < 8 && exec_ready !== 1'b1; i++) @(negedge ref_clk);
    e_sleep = 1'b0;
    chk1(exec_ready, 1'b1, "woken");
    @(posedge ref_clk);
    wake_in <= 1'b0;
    run_op(exclusive_or_literal_op, 1'b0, 7'h00, 8'ha5);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule : tb
